/* File: logic/mtcd_pkg.sv */
// Functional notes
// - Test mode keeps USB, stops drive bridging
// - Drive reset line low at power-up: test mode
// - Memory command: byte0 signature, byte1 0x26
// - Memory transfer at most 255 bytes
// - Byte count from wrapper bytes 8 to 11
// - Direction from wrapper byte 12 bit 7
// - Wrapper field offsets fixed, block at 15-30
// - Pin command: signature, 0x27, rest zero; decoder checks only signature and 0x27
// - Pin load enters pin mode, drives pins
// - Only load bytes 0-3 reach pins
// - Pin mode left only by hard reset
// - Pin read returns request-time input snapshot
// - Byte 0 bit map of control pins
// - Byte 1 bit 7 enables data drivers
// - Byte 1 bit 6 reports test-select input
// - Bad memory signature at power-up: test mode
// - Vendor signature read from config byte 0x04
package mtcd_pkg;
  // ==========================================================
  // Command block codes
  localparam logic [7:0] SUB_CFG = 8'h26;
  localparam logic [7:0] SUB_PIN = 8'h27;
  localparam logic [7:0] DATA_SRC_EE = 8'h02;
  localparam logic [31:0] CFG_MAX_LEN = 32'h0000_00FF;
  // ==========================================================
  // Configuration memory layout
  localparam logic [7:0] EE_SIG0 = 8'h53;
  localparam logic [7:0] EE_SIG1 = 8'h4B;
  localparam logic [7:0] EE_ADDR_SIG0 = 8'h00;
  localparam logic [7:0] EE_ADDR_SIG1 = 8'h01;
  localparam logic [7:0] EE_ADDR_VSIG = 8'h04;
  localparam logic [7:0] EE_ADDR_START = 8'h00;
  // ==========================================================
  // Wrapper byte offsets
  localparam logic [4:0] CBW_LAST = 5'h1E;
  localparam int OFS_LEN = 8;
  localparam int OFS_FLAGS = 12;
  localparam int OFS_CB = 15;
  localparam int CB_SUB = 1;
  localparam int CB_SRC = 3;
  localparam int CB_ADDR_L = 4;
  localparam int CB_ADDR_H = 5;
  localparam int DIR_BIT = 7;
  // ==========================================================
  // Pin data bytes and bits
  localparam logic [7:0] PB_CTL = 8'h00;
  localparam logic [7:0] PB_HS = 8'h01;
  localparam logic [7:0] PB_DDL = 8'h02;
  localparam logic [7:0] PB_DDH = 8'h03;
  localparam logic [7:0] CTL_LOAD_MASK = 8'hBE;
  localparam logic [7:0] HS_READ_MASK = 8'h7F;
  localparam logic [7:0] CTL_RESET = 8'h80;
  localparam int CTL_RST_BIT = 7;
  localparam int CTL_CS_HI = 5;
  localparam int CTL_CS_LO = 4;
  localparam int CTL_PWR_BIT = 3;
  localparam int CTL_DA_HI = 2;
  localparam int CTL_DA_LO = 1;
  localparam int HS_DRIVE_BIT = 7;
  localparam int HS_SEL_BIT = 6;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // ==========================================================
  // Command status and APB map
  localparam logic [1:0] ST_PASS = 2'h0;
  localparam logic [1:0] ST_FAIL = 2'h1;
  localparam logic [1:0] ST_NOT_VENDOR = 2'h2;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_LEN = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // ==========================================================
  // Sequencer states, Gray along the boot path from S_STRAP to S_DECODE
  typedef enum logic [3:0] {
    S_STRAP = 4'h0,
    S_SIG0 = 4'h1,
    S_SIG1 = 4'h3,
    S_VSIG = 4'h2,
    S_IDLE = 4'h6,
    S_DECODE = 4'h7,
    S_CFG_OUT = 4'h5,
    S_CFG_IN = 4'h4,
    S_PIN_OUT = 4'hC,
    S_PIN_IN = 4'hD,
    S_DONE = 4'hF
  } mtcd_state_type;
endpackage

/* File: logic/mtcd_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Byte FIFO on the path to the host
module mtcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // Drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Honest full and empty from the fill count
  assign wr_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign rd_valid = (cnt_ff != '0);
  assign rd_data = mem_ff[rptr_ff];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;

  // Storage needs no reset, the count guards it
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wptr_ff] <= wr_data;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= wrap_inc(wptr_ff);
      end
      if (pop) begin
        rptr_ff <= wrap_inc(rptr_ff);
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==========================================================
// Manufacturing test command decoder
module mtcd_top #(
  parameter logic [7:0] VSIG_DEFAULT = 8'h24,
  parameter bit FUSED_PROGRAMMED = 1'b0,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bulk OUT bytes: wrapper then data
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  // Bulk IN bytes
  output logic in_valid,
  output logic [7:0] in_data,
  input wire logic in_ready,
  // Command completion
  output logic cmd_done,
  output logic [1:0] cmd_status,
  // Configuration memory port
  input wire logic ee_present,
  output logic ee_req,
  output logic ee_we,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_wdata,
  input wire logic ee_ack,
  input wire logic [7:0] ee_rdata,
  // Pin inputs, asynchronous
  input wire logic [7:0] ctl_pins_in,
  input wire logic [7:0] hs_pins_in,
  input wire logic [15:0] dd_in,
  // Mode and pin-test outputs
  output logic mfg_test_mode,
  output logic pin_test_active,
  output logic bridge_enable,
  output logic pt_drive_reset_line_n,
  output logic [1:0] pt_cs_n,
  output logic pt_drive_power_valid,
  output logic [1:0] pt_da,
  output logic [15:0] pt_dd_out,
  output logic [15:0] pt_dd_oe
);
  mtcd_pkg::mtcd_state_type state_ff;
  mtcd_pkg::mtcd_state_type nxt_state;
  logic [31:0] meta_ff;
  logic [31:0] sync_ff;
  logic [7:0] cbw_ff [0:30];
  logic [4:0] cnt_ff;
  logic [1:0] wait_ff;
  logic mfg_mode_ff;
  logic pin_mode_ff;
  logic sig_bad_ff;
  logic [7:0] vsig_ff;
  logic [31:0] rem_ff;
  logic [7:0] idx_ff;
  logic [1:0] st_ff;
  logic [31:0] snap_ff;
  logic [7:0] pt_ctl_ff;
  logic pt_drive_ff;
  logic [15:0] pt_dd_ff;
  logic ee_req_ff;
  logic ee_we_ff;
  logic [7:0] ee_addr_ff;
  logic [7:0] ee_wdata_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] count_ff;
  logic [31:0] prdata_ff;
  logic [7:0] cb0;
  logic [7:0] cb1;
  logic [31:0] xfer_len;
  logic dir_in;
  logic is_vendor;
  logic is_cfg;
  logic is_pin;
  logic cfg_ok;
  logic ee_take;
  logic out_take;
  logic fifo_wr_valid;
  logic fifo_wr_ready;
  logic [7:0] fifo_wr_data;
  logic [7:0] snap_sel;
  logic apb_hit;
  logic [31:0] apb_rmux;

  // Two-flop synchroniser for every pin input
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {dd_in, hs_pins_in, ctl_pins_in};
      sync_ff <= meta_ff;
    end
  end

  // Wrapper field decode
  assign cb0 = cbw_ff[mtcd_pkg::OFS_CB];
  assign cb1 = cbw_ff[mtcd_pkg::OFS_CB + mtcd_pkg::CB_SUB];
  assign xfer_len = {cbw_ff[mtcd_pkg::OFS_LEN + 3], cbw_ff[mtcd_pkg::OFS_LEN + 2],
                     cbw_ff[mtcd_pkg::OFS_LEN + 1], cbw_ff[mtcd_pkg::OFS_LEN]};
  assign dir_in = cbw_ff[mtcd_pkg::OFS_FLAGS][mtcd_pkg::DIR_BIT];
  assign is_vendor = ctrl_ff[0] && (cb0 == vsig_ff);
  assign is_cfg = is_vendor && (cb1 == mtcd_pkg::SUB_CFG);
  assign is_pin = is_vendor && (cb1 == mtcd_pkg::SUB_PIN);
  // Source and start address are trusted only when as expected
  assign cfg_ok = (cbw_ff[mtcd_pkg::OFS_CB + mtcd_pkg::CB_SRC] == mtcd_pkg::DATA_SRC_EE)
                  && (cbw_ff[mtcd_pkg::OFS_CB + mtcd_pkg::CB_ADDR_L] == '0)
                  && (cbw_ff[mtcd_pkg::OFS_CB + mtcd_pkg::CB_ADDR_H] == '0)
                  && (xfer_len <= mtcd_pkg::CFG_MAX_LEN);

  // Stream handshakes
  assign ee_take = ee_req_ff && ee_ack;
  assign out_ready = (state_ff == mtcd_pkg::S_IDLE)
                     || ((state_ff == mtcd_pkg::S_CFG_OUT) && !ee_req_ff && (rem_ff != '0))
                     || ((state_ff == mtcd_pkg::S_PIN_OUT) && (rem_ff != '0));
  assign out_take = out_valid && out_ready;
  assign snap_sel = (idx_ff == mtcd_pkg::PB_CTL) ? snap_ff[7:0] :
                    (idx_ff == mtcd_pkg::PB_HS) ? snap_ff[15:8] :
                    (idx_ff == mtcd_pkg::PB_DDL) ? snap_ff[23:16] :
                    (idx_ff == mtcd_pkg::PB_DDH) ? snap_ff[31:24] : 8'h00;
  // Memory reads only start with FIFO room, so the push never stalls
  assign fifo_wr_valid = ((state_ff == mtcd_pkg::S_CFG_IN) && ee_take)
                         || ((state_ff == mtcd_pkg::S_PIN_IN) && (rem_ff != '0));
  assign fifo_wr_data = (state_ff == mtcd_pkg::S_CFG_IN) ? ee_rdata : snap_sel;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mtcd_pkg::S_STRAP: begin
        if (wait_ff == mtcd_pkg::STRAP_WAIT) begin
          nxt_state = ee_present ? mtcd_pkg::S_SIG0 : mtcd_pkg::S_IDLE;
        end
      end
      mtcd_pkg::S_SIG0: begin
        if (ee_take) begin
          nxt_state = mtcd_pkg::S_SIG1;
        end
      end
      mtcd_pkg::S_SIG1: begin
        if (ee_take) begin
          nxt_state = mtcd_pkg::S_VSIG;
        end
      end
      mtcd_pkg::S_VSIG: begin
        if (ee_take) begin
          nxt_state = mtcd_pkg::S_IDLE;
        end
      end
      mtcd_pkg::S_IDLE: begin
        if (out_take && (cnt_ff == mtcd_pkg::CBW_LAST)) begin
          nxt_state = mtcd_pkg::S_DECODE;
        end
      end
      mtcd_pkg::S_DECODE: begin
        nxt_state = mtcd_pkg::S_DONE;
        if (is_cfg && cfg_ok && mfg_mode_ff) begin
          nxt_state = dir_in ? mtcd_pkg::S_CFG_IN : mtcd_pkg::S_CFG_OUT;
        end else if (is_pin && mfg_mode_ff) begin
          nxt_state = dir_in ? mtcd_pkg::S_PIN_IN : mtcd_pkg::S_PIN_OUT;
        end
      end
      mtcd_pkg::S_CFG_OUT, mtcd_pkg::S_CFG_IN, mtcd_pkg::S_PIN_OUT, mtcd_pkg::S_PIN_IN: begin
        if (rem_ff == '0) begin
          nxt_state = mtcd_pkg::S_DONE;
        end
      end
      default: begin
        nxt_state = mtcd_pkg::S_IDLE;
      end
    endcase
  end

  // Sequencer, boot reads and command bookkeeping
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= mtcd_pkg::S_STRAP;
      cnt_ff <= '0;
      wait_ff <= '0;
      mfg_mode_ff <= 1'b0;
      sig_bad_ff <= 1'b0;
      vsig_ff <= '0;
      rem_ff <= '0;
      idx_ff <= '0;
      st_ff <= mtcd_pkg::ST_PASS;
      snap_ff <= '0;
      count_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      case (state_ff)
        mtcd_pkg::S_STRAP: begin
          wait_ff <= wait_ff + 2'h1;
          if (wait_ff == mtcd_pkg::STRAP_WAIT) begin
            mfg_mode_ff <= !sync_ff[mtcd_pkg::CTL_RST_BIT];
            if (!ee_present) begin
              vsig_ff <= VSIG_DEFAULT;
              if (!FUSED_PROGRAMMED) begin
                mfg_mode_ff <= 1'b1;
              end
            end
          end
        end
        mtcd_pkg::S_SIG0: begin
          if (ee_take) begin
            sig_bad_ff <= (ee_rdata != mtcd_pkg::EE_SIG0);
          end
        end
        mtcd_pkg::S_SIG1: begin
          if (ee_take && (sig_bad_ff || (ee_rdata != mtcd_pkg::EE_SIG1))) begin
            mfg_mode_ff <= 1'b1;
          end
        end
        mtcd_pkg::S_VSIG: begin
          if (ee_take) begin
            vsig_ff <= ee_rdata;
          end
        end
        mtcd_pkg::S_IDLE: begin
          if (out_take) begin
            cnt_ff <= (cnt_ff == mtcd_pkg::CBW_LAST) ? 5'h00 : cnt_ff + 5'h01;
          end
        end
        mtcd_pkg::S_DECODE: begin
          rem_ff <= xfer_len;
          idx_ff <= '0;
          snap_ff <= {sync_ff[31:16], sync_ff[15:8] & mtcd_pkg::HS_READ_MASK,
                      sync_ff[7:0]};
          st_ff <= !is_vendor ? mtcd_pkg::ST_NOT_VENDOR :
                   (nxt_state == mtcd_pkg::S_DONE) ? mtcd_pkg::ST_FAIL : mtcd_pkg::ST_PASS;
        end
        mtcd_pkg::S_DONE: begin
          count_ff <= count_ff + 32'h0000_0001;
        end
        default: begin
          // Data phases count bytes as they move
          if (ee_take || (out_take && (state_ff == mtcd_pkg::S_PIN_OUT))
              || (fifo_wr_valid && fifo_wr_ready && (state_ff == mtcd_pkg::S_PIN_IN))) begin
            rem_ff <= rem_ff - 32'h0000_0001;
            idx_ff <= (idx_ff == 8'hFF) ? idx_ff : idx_ff + 8'h01;
          end
        end
      endcase
    end
  end

  // Wrapper capture, no reset needed on the byte store
  always_ff @(posedge core_clk) begin
    if ((state_ff == mtcd_pkg::S_IDLE) && out_take) begin
      cbw_ff[cnt_ff] <= out_data;
    end
  end

  // Configuration memory requests, one outstanding at a time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ee_req_ff <= 1'b0;
      ee_we_ff <= 1'b0;
      ee_addr_ff <= '0;
      ee_wdata_ff <= '0;
    end else if (ee_take) begin
      ee_req_ff <= 1'b0;
      ee_addr_ff <= ee_addr_ff + 8'h01;
    end else if (!ee_req_ff) begin
      case (state_ff)
        mtcd_pkg::S_SIG0, mtcd_pkg::S_SIG1, mtcd_pkg::S_VSIG: begin
          ee_req_ff <= 1'b1;
          ee_we_ff <= 1'b0;
          ee_addr_ff <= (state_ff == mtcd_pkg::S_SIG0) ? mtcd_pkg::EE_ADDR_SIG0 :
                        (state_ff == mtcd_pkg::S_SIG1) ? mtcd_pkg::EE_ADDR_SIG1 :
                        mtcd_pkg::EE_ADDR_VSIG;
        end
        mtcd_pkg::S_DECODE: begin
          ee_addr_ff <= mtcd_pkg::EE_ADDR_START;
        end
        mtcd_pkg::S_CFG_OUT: begin
          if (out_take) begin
            ee_req_ff <= 1'b1;
            ee_we_ff <= 1'b1;
            ee_wdata_ff <= out_data;
          end
        end
        mtcd_pkg::S_CFG_IN: begin
          if ((rem_ff != '0) && fifo_wr_ready) begin
            ee_req_ff <= 1'b1;
            ee_we_ff <= 1'b0;
          end
        end
        default: begin
          ee_req_ff <= 1'b0;
        end
      endcase
    end
  end

  // Pin-test mode and loaded pin values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_mode_ff <= 1'b0;
      pt_ctl_ff <= mtcd_pkg::CTL_RESET;
      pt_drive_ff <= 1'b0;
      pt_dd_ff <= '0;
    end else begin
      if (nxt_state == mtcd_pkg::S_PIN_OUT) begin
        pin_mode_ff <= 1'b1;
      end
      if ((state_ff == mtcd_pkg::S_PIN_OUT) && out_take) begin
        case (idx_ff)
          mtcd_pkg::PB_CTL: pt_ctl_ff <= out_data & mtcd_pkg::CTL_LOAD_MASK;
          mtcd_pkg::PB_HS: pt_drive_ff <= out_data[mtcd_pkg::HS_DRIVE_BIT];
          mtcd_pkg::PB_DDL: pt_dd_ff[7:0] <= out_data;
          mtcd_pkg::PB_DDH: pt_dd_ff[15:8] <= out_data;
          default: pt_dd_ff <= pt_dd_ff;
        endcase
      end
    end
  end

  // Pin and mode outputs; bridging stops in test mode
  assign mfg_test_mode = mfg_mode_ff;
  assign pin_test_active = pin_mode_ff;
  assign bridge_enable = !mfg_mode_ff && !pin_mode_ff;
  assign pt_drive_reset_line_n = pt_ctl_ff[mtcd_pkg::CTL_RST_BIT];
  assign pt_cs_n = pt_ctl_ff[mtcd_pkg::CTL_CS_HI:mtcd_pkg::CTL_CS_LO];
  assign pt_drive_power_valid = pt_ctl_ff[mtcd_pkg::CTL_PWR_BIT];
  assign pt_da = pt_ctl_ff[mtcd_pkg::CTL_DA_HI:mtcd_pkg::CTL_DA_LO];
  assign pt_dd_out = pt_dd_ff;
  assign pt_dd_oe = {16{pin_mode_ff && pt_drive_ff}};
  assign cmd_done = (state_ff == mtcd_pkg::S_DONE);
  assign cmd_status = st_ff;
  assign ee_req = ee_req_ff;
  assign ee_we = ee_we_ff;
  assign ee_addr = ee_addr_ff;
  assign ee_wdata = ee_wdata_ff;

  // Host-bound bytes; a full FIFO stalls the data phase
  mtcd_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(fifo_wr_data),
    .rd_valid(in_valid),
    .rd_ready(in_ready),
    .rd_data(in_data)
  );

  // APB: zero wait, read data latched in the setup cycle
  assign apb_hit = (paddr == mtcd_pkg::ADDR_STATUS) || (paddr == mtcd_pkg::ADDR_CTRL)
                   || (paddr == mtcd_pkg::ADDR_COUNT) || (paddr == mtcd_pkg::ADDR_LEN);
  assign apb_rmux = (paddr == mtcd_pkg::ADDR_STATUS) ?
                      {16'h0000, vsig_ff, 2'b00, st_ff, 1'b0,
                       (state_ff != mtcd_pkg::S_IDLE), pin_mode_ff, mfg_mode_ff} :
                    (paddr == mtcd_pkg::ADDR_CTRL) ? ctrl_ff :
                    (paddr == mtcd_pkg::ADDR_COUNT) ? count_ff :
                    (paddr == mtcd_pkg::ADDR_LEN) ? rem_ff : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apb_hit;
  assign prdata = prdata_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= mtcd_pkg::CTRL_RESET;
      prdata_ff <= '0;
    end else begin
      if (psel && !penable) begin
        prdata_ff <= apb_rmux;
      end
      if (psel && penable && pwrite && (paddr == mtcd_pkg::ADDR_CTRL)) begin
        ctrl_ff <= pwdata;
      end
    end
  end

  // ==========================================================
  // Assertions
  property p_strap;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_STRAP && nxt_state != mtcd_pkg::S_STRAP
     && !sync_ff[mtcd_pkg::CTL_RST_BIT]) |=> mfg_mode_ff;
  endproperty
  a_strap: assert property (p_strap) else $error("strap low did not enter test mode");

  property p_cfg_sel;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_DECODE && (nxt_state == mtcd_pkg::S_CFG_IN
     || nxt_state == mtcd_pkg::S_CFG_OUT)) |-> (cb0 == vsig_ff && cb1 == mtcd_pkg::SUB_CFG);
  endproperty
  a_cfg_sel: assert property (p_cfg_sel) else $error("memory command wrongly decoded");

  property p_cfg_max;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_DECODE && is_cfg && xfer_len > mtcd_pkg::CFG_MAX_LEN)
    |=> (cmd_done && cmd_status == mtcd_pkg::ST_FAIL);
  endproperty
  a_cfg_max: assert property (p_cfg_max) else $error("oversize transfer not failed");

  property p_len;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_DECODE) |=> (rem_ff == $past(xfer_len));
  endproperty
  a_len: assert property (p_len) else $error("byte count not from wrapper");

  property p_dir;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_DECODE && nxt_state == mtcd_pkg::S_CFG_IN) |-> dir_in;
  endproperty
  a_dir: assert property (p_dir) else $error("read chosen against direction flag");

  property p_sticky;
    @(posedge core_clk) disable iff (rst)
    pin_mode_ff |=> (pin_mode_ff && !bridge_enable) [*2];
  endproperty
  a_sticky: assert property (p_sticky) else $error("pin mode left without reset");

  property p_dd_low;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_PIN_OUT && out_take && idx_ff == mtcd_pkg::PB_DDL)
    |=> (pt_dd_out[7:0] == $past(out_data) && pin_test_active);
  endproperty
  a_dd_low: assert property (p_dd_low) else $error("byte 2 not on data bits 7:0");

  property p_drive_off;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_PIN_OUT && out_take && idx_ff == mtcd_pkg::PB_HS
     && !out_data[mtcd_pkg::HS_DRIVE_BIT]) |=> (pt_dd_oe == 16'h0000);
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("data pins driven when off");

  property p_rst_line;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_PIN_OUT && out_take && idx_ff == mtcd_pkg::PB_CTL)
    |=> (pt_drive_reset_line_n == $past(out_data[mtcd_pkg::CTL_RST_BIT]));
  endproperty
  a_rst_line: assert property (p_rst_line) else $error("byte 0 bit 7 not on reset line");

  property p_unknown;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_DECODE && is_vendor && !is_cfg && !is_pin)
    |=> (cmd_done && cmd_status == mtcd_pkg::ST_FAIL && $stable(pin_mode_ff) && !ee_req);
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown subcommand not failed");

  property p_snap;
    @(posedge core_clk) disable iff (rst)
    (state_ff == mtcd_pkg::S_PIN_IN && fifo_wr_valid && idx_ff == mtcd_pkg::PB_DDH)
    |-> (fifo_wr_data == snap_ff[31:24]);
  endproperty
  a_snap: assert property (p_snap) else $error("read byte 3 not from snapshot");

  c_pin_load: cover property (@(posedge core_clk) disable iff (rst)
    state_ff == mtcd_pkg::S_PIN_OUT ##1 state_ff == mtcd_pkg::S_DONE);
  c_cfg_read: cover property (@(posedge core_clk) disable iff (rst)
    state_ff == mtcd_pkg::S_CFG_IN && !fifo_wr_ready);
  c_cfg_write: cover property (@(posedge core_clk) disable iff (rst)
    state_ff == mtcd_pkg::S_CFG_OUT && ee_take);
endmodule

`default_nettype wire

/* File: verif/mtcd_ee_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Configuration memory, answering fast and slow in turn
module mtcd_ee_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request side
  input wire logic ee_req,
  input wire logic ee_we,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_wdata,
  output logic ee_ack,
  output logic [7:0] ee_rdata
);
  logic [7:0] mem_ff [0:255];
  logic [1:0] wait_ff;
  logic slow_ff;
  // Valid signature, vendor code at 0x04, filler elsewhere
  initial begin
    for (int k = 0; k < 256; k++) mem_ff[k] = 8'(k);
    mem_ff[0] = 8'h53;
    mem_ff[1] = 8'h4B;
    mem_ff[4] = 8'h5A;
  end
  // Read data garbles while no request waits and holds during a wait; fresh only in the ack cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ee_ack <= 1'b0;
      ee_rdata <= 8'h00;
      wait_ff <= 2'h0;
      slow_ff <= 1'b0;
    end else if (ee_req && !ee_ack) begin
      wait_ff <= wait_ff + 2'h1;
      if (wait_ff == {slow_ff, 1'b1}) begin
        ee_ack <= 1'b1;
        wait_ff <= 2'h0;
        slow_ff <= !slow_ff;
        if (ee_we) mem_ff[ee_addr] <= ee_wdata;
        else ee_rdata <= mem_ff[ee_addr];
      end
    end else begin
      ee_ack <= 1'b0;
      ee_rdata <= ~ee_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: verif/mtcd_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for the test command decoder
module mtcd_top_tb;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic out_valid = 1'b0, in_ready = 1'b0, ee_present = 1'b1, e;
  logic [7:0] paddr = 8'h00, out_data = 8'h00, ctl_pins_in = 8'h00, hs_pins_in = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic [15:0] dd_in = 16'h0, pt_dd_out, pt_dd_oe;
  logic pready, pslverr, out_ready, in_valid, cmd_done, ee_req, ee_we, ee_ack;
  logic mfg_test_mode, pin_test_active, bridge_enable;
  logic pt_drive_reset_line_n, pt_drive_power_valid;
  logic [7:0] in_data, ee_addr, ee_wdata, ee_rdata;
  logic [1:0] cmd_status, pt_cs_n, pt_da, last_st;
  int n_errors = 0, tests_run = 0, n_done = 0, i;
  // Small FIFO so a six byte read must stall
  mtcd_top #(.FIFO_DEPTH(4)) dut (.*);
  mtcd_ee_model ee (.*);
  always #25 core_clk = ~core_clk;
  // Completions are pulses, so count them as they pass
  always @(posedge core_clk) if (cmd_done === 1'b1) begin
    n_done <= n_done + 1;
    last_st <= cmd_status;
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task tmo;
    n_errors++;
    tally_and_finish();
  endtask
  // Setup, access until pready; data and error taken at that same edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i >= 50) tmo();
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge core_clk);
  endtask
  // Byte held until a take edge; valid stays up between bytes
  task send(input logic [7:0] b);
    out_valid <= 1'b1;
    out_data <= b;
    for (i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if (out_ready === 1'b1) break;
    end
    if (i >= 200) tmo();
    @(posedge core_clk);
  endtask
  task cbw(input logic [7:0] sg, input logic [7:0] sb, input logic [15:0] ln, input logic dr);
    logic [247:0] w;
    // Source byte only in memory commands; pin commands keep the block zero
    w = {96'h0, ((sb == 8'h26) ? 8'h02 : 8'h00), 8'h00, sb, sg, 16'h1000, dr, 23'h0, ln,
         64'h43425355};
    for (int k = 0; k < 31; k++) send(w[8*k +: 8]);
  endtask
  task drain(input int n, input logic [63:0] x);
    in_ready <= 1'b1;
    for (int k = 0; k < n; k++) begin
      for (i = 0; i < 200; i++) begin
        @(negedge core_clk);
        if (in_valid === 1'b1) break;
      end
      if (i >= 200) tmo();
      chk({24'h0, in_data}, {24'h0, x[8*k +: 8]});
      @(posedge core_clk);
    end
    in_ready <= 1'b0;
  endtask
  task wait_done(input int k, input logic [1:0] st);
    for (i = 0; i < 2000 && n_done != k; i++) @(posedge core_clk);
    if (i >= 2000) tmo();
    chk({30'h0, last_st}, {30'h0, st});
  endtask
  // ==========================================================
  // Main sequence: boot, memory read, pin read and load, refusals
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 500 && out_ready !== 1'b1; i++) @(posedge core_clk);
    if (i >= 500) tmo();
    chk({30'h0, mfg_test_mode, bridge_enable}, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_5A01);
    apb(1'b0, 8'h40, 32'h0);
    chk({q[30:0], e}, 32'h1);
    {ctl_pins_in, hs_pins_in, dd_in} <= 32'h65C3_A55A;
    cbw(8'h5A, 8'h26, 16'h0003, 1'b1);
    out_valid <= 1'b0;
    drain(3, 64'h02_4B53);
    wait_done(1, 2'h0);
    cbw(8'h5A, 8'h27, 16'h0006, 1'b1);
    out_valid <= 1'b0;
    repeat (20) @(posedge core_clk);
    drain(6, 64'h0000_A55A_4365);
    wait_done(2, 2'h0);
    cbw(8'h5A, 8'h27, 16'h0004, 1'b0);
    for (int k = 0; k < 4; k++) send(8'(32'h1234_80B6 >> 8*k));
    out_valid <= 1'b0;
    wait_done(3, 2'h0);
    chk({pt_dd_oe, pt_dd_out}, 32'hFFFF_1234);
    cbw(8'h5A, 8'h30, 16'h0000, 1'b0);
    out_valid <= 1'b0;
    wait_done(4, 2'h1);
    chk({24'h0, pin_test_active, bridge_enable, pt_drive_reset_line_n, pt_cs_n,
      pt_drive_power_valid, pt_da}, 32'hBB);
    cbw(8'h11, 8'h26, 16'h0000, 1'b0);
    out_valid <= 1'b0;
    wait_done(5, 2'h2);
    // Oversize memory command fails, no data moved
    cbw(8'h5A, 8'h26, 16'h0100, 1'b1);
    out_valid <= 1'b0;
    wait_done(6, 2'h1);
    // Decode switched off: even a good command is foreign
    apb(1'b1, 8'h04, 32'h0);
    cbw(8'h5A, 8'h27, 16'h0000, 1'b1);
    out_valid <= 1'b0;
    wait_done(7, 2'h2);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h1);
    // Long load with drivers off; bytes past 3 are dropped
    cbw(8'h5A, 8'h27, 16'h0006, 1'b0);
    for (int k = 0; k < 6; k++) send(8'(48'hFFEE_ABCD_7F48 >> 8*k));
    out_valid <= 1'b0;
    wait_done(8, 2'h0);
    chk({pt_dd_oe, pt_dd_out}, 32'h0000_ABCD);
    chk({24'h0, pin_test_active, bridge_enable, pt_drive_reset_line_n, pt_cs_n,
      pt_drive_power_valid, pt_da}, 32'h84);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
